// File: logic/blc_codec.sv
// host-side line encoder and decoder for a half-duplex radio module
// assumes txd/select pins wired to the module, rxd and carrier detect
// arriving asynchronously; one clock, async active-high reset
//
// Function
// [RULE1] all line coding and recovery happen here
// [RULE2] edges on txd are spaced above 25 us and below 2 ms
// [RULE3] send at least 3 ms of 1010 preamble; ignore rxd before it settles
// [RULE4] preamble stretched to 5 ms
// [RULE5] transmit waveform balanced high/low, never beyond 30/70
// [RULE6] packet bytes follow back to back without idle gaps
// [RULE7] order: 55h preamble, FFh sync, 01h start, data, checksum
// [RULE8] above 20 kbit/s only balanced codes are sent
// [RULE9] manchester: value then inverse per bit, 250 bit/s to 40 kbit/s
// [RULE10] thirds: low, data, high per bit; falling edge aligns decoder
// [RULE11] thirds bit period at least 100 us
// [RULE12] byte coding uses four-ones symbols, never 0Fh or F0h; tx sends bytes as given, FFh sync, 01h start and checksum included
// [RULE13] byte-coded symbols go as consecutive synchronous bytes
// [RULE14] byte coding bit rate between 2 and 40 kbit/s
// [RULE15] received symbol without exactly four ones flags a byte error
// [RULE16] duplicate mode sends each byte true, then complemented; tx doubles only data and checksum bytes, not preamble, sync or start
// [RULE17] on a bad true byte the decoder uses the complement copy
// [RULE18] packet closes with a 16-bit checksum the receiver verifies
// [RULE19] txd held low whenever no transmission is running
// [RULE20] manchester decoder samples both halves, equal halves are errors
// [RULE21] framer drops preamble and sync, starts after 01h, reports checksum
`timescale 1ns/1ps
`include "blc_defs.svh"

module blc_codec #(
    parameter logic [`BLC_CNT_W-1:0] SLOT_CYC = `BLC_CNT_W'(`BLC_SLOT_CYC)
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [1:0] mode,
    input  wire logic       dup_en,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_go,
    output logic            tx_busy,
    input  wire logic       rx_en,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_done,
    output logic            rx_ok,
    output logic            rx_sym_err,
    output logic            rx_bal_err,
    output logic            txd,
    output logic            tx_sel_n,
    output logic            rx_sel_n,
    input  wire logic       rxd,
    input  wire logic       carrier_detect_output
);
    blc_pkg::blc_state_t r_reg;
    blc_pkg::blc_state_t r_next;
    logic                f_valid;
    logic                f_pop;
    logic [7:0]          f_data;

    // payload queue, so the packet goes out gap-free
    blc_fifo #(
        .WIDTH (`BLC_FIFO_W),
        .DEPTH (`BLC_FIFO_D)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    function automatic logic [1:0] last_ph(input blc_pkg::blc_mode_t m);
        case (m)
            blc_pkg::BLC_MANCH:  last_ph = 2'h1;
            blc_pkg::BLC_THIRDS: last_ph = 2'h2; // RULE11
            default:             last_ph = 2'h0; // RULE14
        endcase
    endfunction

    function automatic logic line_of(input blc_pkg::blc_mode_t m, input logic [1:0] ph, input logic b);
        case (m)
            blc_pkg::BLC_MANCH:  line_of = (ph == 2'h0) ? b : !b; // RULE9
            blc_pkg::BLC_THIRDS: line_of = (ph == 2'h0) ? 1'b0 : ((ph == 2'h1) ? b : 1'b1); // RULE10
            default:             line_of = b; // RULE13
        endcase
    endfunction

    logic       tx_tick;
    logic       tx_bend;
    logic       rx_tick;
    logic       rx_samp;
    logic       edge_seen;
    logic       fall;
    logic       listen;
    logic       got;
    logic       bitv;
    logic       err;
    logic       bad;
    logic [7:0] nsh;
    logic [7:0] pick;
    logic       push;

    always_comb begin
        r_next = r_reg;
        f_pop  = 1'b0;
        // transmit byte engine
        tx_tick = r_reg.tx_on && (r_reg.tx_cnt == SLOT_CYC - 1'b1);
        tx_bend = tx_tick && (r_reg.tx_ph == last_ph(r_reg.tx_mode)) && (r_reg.tx_bit == 3'h7);
        if (r_reg.tx_on) begin
            r_next.tx_cnt = tx_tick ? '0 : r_reg.tx_cnt + 1'b1; // RULE2
            if (tx_tick) begin
                if (r_reg.tx_ph == last_ph(r_reg.tx_mode)) begin
                    r_next.tx_ph  = 2'h0;
                    r_next.tx_bit = r_reg.tx_bit + 1'b1;
                    r_next.tx_sh  = {1'b0, r_reg.tx_sh[7:1]};
                end else begin
                    r_next.tx_ph = r_reg.tx_ph + 1'b1;
                end
                if (r_reg.tx_st == blc_pkg::TX_PRE && r_reg.tx_pre != 8'(`BLC_PRE_SLOTS)) begin
                    r_next.tx_pre = r_reg.tx_pre + 1'b1; // RULE3 RULE4
                end
            end
        end
        if ((r_reg.tx_st == blc_pkg::TX_IDLE && tx_go && f_valid) || tx_bend) begin
            r_next.tx_bit = 3'h0;
            r_next.tx_ph  = 2'h0;
            r_next.tx_cnt = '0;
            if (r_reg.tx_dup && !r_reg.tx_cp && (r_reg.tx_st == blc_pkg::TX_DAT ||
                r_reg.tx_st == blc_pkg::TX_CKH || r_reg.tx_st == blc_pkg::TX_CKL)) begin
                r_next.tx_sh = ~r_reg.tx_held; // RULE16
                r_next.tx_cp = 1'b1;
            end else begin
                r_next.tx_cp = 1'b0;
                case (r_reg.tx_st)
                    blc_pkg::TX_IDLE: begin
                        r_next.tx_on   = 1'b1;
                        r_next.tx_mode = blc_pkg::blc_mode_t'(mode);
                        r_next.tx_dup  = dup_en;
                        r_next.tx_sh   = `BLC_PRE_BYTE; // RULE7
                        r_next.tx_pre  = 8'h0;
                        r_next.tx_sum  = 16'h0;
                        r_next.tx_st   = blc_pkg::TX_PRE;
                    end
                    blc_pkg::TX_PRE: begin
                        if (r_reg.tx_pre == 8'(`BLC_PRE_SLOTS)) begin
                            r_next.tx_sh = `BLC_SYNC_BYTE; // RULE7
                            r_next.tx_nb = 2'h1;
                            r_next.tx_st = blc_pkg::TX_SYN;
                        end else begin
                            r_next.tx_sh = `BLC_PRE_BYTE; // RULE3
                        end
                    end
                    blc_pkg::TX_SYN: begin
                        if (r_reg.tx_nb == `BLC_SYNC_CNT) begin
                            r_next.tx_sh = `BLC_START_BYTE; // RULE7
                            r_next.tx_st = blc_pkg::TX_STB;
                        end else begin
                            r_next.tx_sh = `BLC_SYNC_BYTE;
                            r_next.tx_nb = r_reg.tx_nb + 1'b1;
                        end
                    end
                    blc_pkg::TX_STB, blc_pkg::TX_DAT: begin
                        if (f_valid) begin
                            f_pop          = 1'b1; // RULE6
                            r_next.tx_sh   = f_data;
                            r_next.tx_held = f_data;
                            r_next.tx_sum  = r_reg.tx_sum + {8'h00, f_data};
                            r_next.tx_st   = blc_pkg::TX_DAT;
                        end else begin
                            r_next.tx_sh   = r_reg.tx_sum[15:8]; // RULE18
                            r_next.tx_held = r_reg.tx_sum[15:8];
                            r_next.tx_st   = blc_pkg::TX_CKH;
                        end
                    end
                    blc_pkg::TX_CKH: begin
                        r_next.tx_sh   = r_reg.tx_sum[7:0]; // RULE18
                        r_next.tx_held = r_reg.tx_sum[7:0];
                        r_next.tx_st   = blc_pkg::TX_CKL;
                    end
                    default: begin
                        r_next.tx_on = 1'b0;
                        r_next.tx_sh = 8'h00;
                        r_next.tx_st = blc_pkg::TX_IDLE;
                    end
                endcase
            end
        end
        // line is idle low outside a packet
        r_next.tx_line = r_next.tx_on ? line_of(r_next.tx_mode, r_next.tx_ph, r_next.tx_sh[0]) : 1'b0; // RULE19 RULE5 RULE8

        // receive pin conditioning
        r_next.rx_sync = {r_reg.rx_sync[1:0], rxd};
        r_next.cd_sync = {r_reg.cd_sync[1:0], carrier_detect_output};
        r_next.rxd_f   = (r_reg.rx_sync[2] == r_reg.rx_sync[1]) ? r_reg.rx_sync[1] : r_reg.rxd_f;
        r_next.cd_f    = (r_reg.cd_sync[2] == r_reg.cd_sync[1]) ? r_reg.cd_sync[1] : r_reg.cd_f;
        r_next.rxd_p = r_reg.rxd_f;
        edge_seen    = r_reg.rxd_f != r_reg.rxd_p;
        fall         = edge_seen && !r_reg.rxd_f;
        listen       = rx_en && !r_reg.tx_on && r_reg.cd_f;
        r_next.rx_valid = 1'b0;
        r_next.rx_done  = 1'b0;

        // slot timing and bit recovery
        rx_tick = r_reg.rx_cnt == SLOT_CYC - 1'b1;
        rx_samp = !edge_seen && (r_reg.rx_cnt == (SLOT_CYC >> 1));
        if (edge_seen) begin
            r_next.rx_cnt = '0;
            if (fall && r_reg.rx_mode == blc_pkg::BLC_THIRDS) begin
                r_next.rx_ph = 2'h0; // RULE10
            end
        end else begin
            r_next.rx_cnt = rx_tick ? '0 : r_reg.rx_cnt + 1'b1;
        end
        got  = 1'b0;
        bitv = 1'b0;
        err  = 1'b0;
        if (rx_samp) begin
            case (r_reg.rx_mode)
                blc_pkg::BLC_MANCH: begin
                    if (r_reg.rx_ph == 2'h0) begin
                        r_next.rx_a  = r_reg.rxd_f;
                        r_next.rx_ph = 2'h1;
                    end else if (r_reg.rxd_f == r_reg.rx_a && r_reg.rx_st == blc_pkg::RX_HUNT) begin
                        err         = 1'b1; // RULE20
                        r_next.rx_a = r_reg.rxd_f;
                    end else begin
                        err          = r_reg.rxd_f == r_reg.rx_a; // RULE20
                        got          = 1'b1;
                        bitv         = r_reg.rx_a;
                        r_next.rx_ph = 2'h0;
                    end
                end
                blc_pkg::BLC_THIRDS: begin
                    got  = r_reg.rx_ph == 2'h1;
                    bitv = r_reg.rxd_f;
                    err  = (r_reg.rx_ph == 2'h0 && r_reg.rxd_f) || (r_reg.rx_ph == 2'h2 && !r_reg.rxd_f);
                    r_next.rx_ph = (r_reg.rx_ph == 2'h2) ? 2'h0 : r_reg.rx_ph + 1'b1;
                end
                default: begin
                    got  = 1'b1;
                    bitv = r_reg.rxd_f;
                end
            endcase
        end
        nsh = {bitv, r_reg.rx_sh[7:1]};
        if (got) begin
            r_next.rx_sh  = nsh;
            r_next.rx_bit = r_reg.rx_bit + 1'b1;
        end

        // receive framer
        bad     = 1'b0;
        pick    = nsh;
        push    = 1'b0;
        case (r_reg.rx_st)
            blc_pkg::RX_OFF: begin
                if (listen) begin
                    r_next.rx_st   = blc_pkg::RX_SETTLE;
                    r_next.rx_set  = 8'h0;
                    r_next.rx_mode = blc_pkg::blc_mode_t'(mode);
                    r_next.rx_dup  = dup_en;
                    r_next.rx_ph   = 2'h0;
                end
            end
            blc_pkg::RX_SETTLE: begin
                if (rx_tick || edge_seen) begin // RULE3
                    r_next.rx_set = r_reg.rx_set + 1'b1;
                end
                if (r_reg.rx_set == 8'(`BLC_SETTLE_SLOTS)) begin
                    r_next.rx_st      = blc_pkg::RX_HUNT; // RULE3
                    r_next.rx_seen_ff = 1'b0;
                    r_next.rx_sh      = 8'h00;
                end
            end
            blc_pkg::RX_HUNT: begin
                if (got && nsh == `BLC_SYNC_BYTE) begin
                    r_next.rx_seen_ff = 1'b1; // RULE21
                end
                if (got && r_reg.rx_seen_ff && nsh == `BLC_START_BYTE) begin
                    r_next.rx_st      = blc_pkg::RX_DATA; // RULE21
                    r_next.rx_bit     = 3'h0;
                    r_next.rx_n       = 2'h0;
                    r_next.rx_sum     = 16'h0;
                    r_next.rx_cp      = 1'b0;
                    r_next.rx_berr    = 1'b0;
                    r_next.rx_sym_err = 1'b0;
                    r_next.rx_bal_err = 1'b0;
                end
            end
            default: begin
                r_next.rx_berr = r_reg.rx_berr | err;
                if (got && r_reg.rx_bit == 3'h7) begin
                    r_next.rx_berr = 1'b0;
                    bad = r_reg.rx_berr | err;
                    if (r_reg.rx_mode == blc_pkg::BLC_NRZ && (4'($countones(nsh)) != `BLC_BAL_ONES ||
                        nsh == `BLC_BAD_LO || nsh == `BLC_BAD_HI)) begin
                        r_next.rx_bal_err = 1'b1; // RULE15 RULE12
                        bad = 1'b1;
                    end
                    r_next.rx_sym_err = r_reg.rx_sym_err | bad;
                    if (!r_reg.rx_dup) begin
                        push = 1'b1;
                    end else if (!r_reg.rx_cp) begin
                        r_next.rx_cp   = 1'b1;
                        r_next.rx_true = nsh;
                        r_next.rx_terr = bad;
                    end else begin
                        r_next.rx_cp = 1'b0;
                        push = 1'b1;
                        pick = r_reg.rx_terr ? ~nsh : r_reg.rx_true; // RULE17
                    end
                end
            end
        endcase
        // last two bytes are held back: they are the checksum
        if (push) begin
            if (r_reg.rx_n == 2'h2) begin
                r_next.rx_data  = r_reg.rx_h2;
                r_next.rx_valid = 1'b1;
                r_next.rx_sum   = r_reg.rx_sum + {8'h00, r_reg.rx_h2};
            end else begin
                r_next.rx_n = r_reg.rx_n + 1'b1;
            end
            r_next.rx_h2 = r_reg.rx_h1;
            r_next.rx_h1 = pick;
        end
        if (!listen && r_reg.rx_st != blc_pkg::RX_OFF) begin
            r_next.rx_st = blc_pkg::RX_OFF;
            if (r_reg.rx_st == blc_pkg::RX_DATA) begin
                r_next.rx_done = 1'b1; // RULE21 RULE18
                r_next.rx_ok   = (r_reg.rx_n == 2'h2) && (r_reg.rx_sum == {r_reg.rx_h2, r_reg.rx_h1});
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next; // RULE1
        end
    end

    assign txd        = r_reg.tx_line;
    assign tx_sel_n   = !r_reg.tx_on;
    assign rx_sel_n   = !(rx_en && !r_reg.tx_on);
    assign tx_busy    = r_reg.tx_on;
    assign rx_data    = r_reg.rx_data;
    assign rx_valid   = r_reg.rx_valid;
    assign rx_done    = r_reg.rx_done;
    assign rx_ok      = r_reg.rx_ok;
    assign rx_sym_err = r_reg.rx_sym_err;
    assign rx_bal_err = r_reg.rx_bal_err;

endmodule

// File: logic/blc_defs.svh
// named constants of the balanced line codec
// assumes a 100 MHz system clock; included by package and modules
`ifndef BLC_DEFS_SVH
`define BLC_DEFS_SVH

`define BLC_CLK_NS       10
`define BLC_SLOT_NS      50000
`define BLC_SLOT_CYC     (`BLC_SLOT_NS / `BLC_CLK_NS)
`define BLC_CNT_W        16
`define BLC_PRE_US       5000
`define BLC_PRE_SLOTS    ((`BLC_PRE_US * 1000 + `BLC_SLOT_NS - 1) / `BLC_SLOT_NS)
`define BLC_SETTLE_US    3000
`define BLC_SETTLE_SLOTS ((`BLC_SETTLE_US * 1000 + `BLC_SLOT_NS - 1) / `BLC_SLOT_NS)
`define BLC_PRE_BYTE     8'h55
`define BLC_SYNC_BYTE    8'hFF
`define BLC_START_BYTE   8'h01
`define BLC_SYNC_CNT     2'h2
`define BLC_BAL_ONES     4'h4
`define BLC_BAD_LO       8'h0F
`define BLC_BAD_HI       8'hF0
`define BLC_FIFO_W       8
`define BLC_FIFO_D       16

`endif

// File: logic/blc_pkg.sv
// types of the balanced line codec: modes, states, state record
// assumes blc_defs.svh on the include path
`include "blc_defs.svh"

package blc_pkg;

    typedef enum logic [1:0] {
        BLC_MANCH  = 2'h0,
        BLC_THIRDS = 2'h1,
        BLC_NRZ    = 2'h2
    } blc_mode_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_PRE  = 3'h1,
        TX_SYN  = 3'h3,
        TX_STB  = 3'h2,
        TX_DAT  = 3'h6,
        TX_CKH  = 3'h7,
        TX_CKL  = 3'h5
    } blc_tx_st_t;

    typedef enum logic [1:0] {
        RX_OFF    = 2'h0,
        RX_SETTLE = 2'h1,
        RX_HUNT   = 2'h3,
        RX_DATA   = 2'h2
    } blc_rx_st_t;

    typedef struct packed {
        blc_tx_st_t           tx_st;
        blc_mode_t            tx_mode;
        logic                 tx_dup;
        logic                 tx_on;
        logic                 tx_line;
        logic [7:0]           tx_sh;
        logic [7:0]           tx_held;
        logic [2:0]           tx_bit;
        logic [1:0]           tx_ph;
        logic [`BLC_CNT_W-1:0] tx_cnt;
        logic [7:0]           tx_pre;
        logic [1:0]           tx_nb;
        logic                 tx_cp;
        logic [15:0]          tx_sum;
        logic [2:0]           rx_sync;
        logic [2:0]           cd_sync;
        logic                 rxd_f;
        logic                 rxd_p;
        logic                 cd_f;
        blc_rx_st_t           rx_st;
        blc_mode_t            rx_mode;
        logic                 rx_dup;
        logic [`BLC_CNT_W-1:0] rx_cnt;
        logic [1:0]           rx_ph;
        logic                 rx_a;
        logic [7:0]           rx_sh;
        logic [2:0]           rx_bit;
        logic                 rx_seen_ff;
        logic [7:0]           rx_set;
        logic                 rx_cp;
        logic [7:0]           rx_true;
        logic                 rx_terr;
        logic                 rx_berr;
        logic [7:0]           rx_h1;
        logic [7:0]           rx_h2;
        logic [1:0]           rx_n;
        logic [15:0]          rx_sum;
        logic [7:0]           rx_data;
        logic                 rx_valid;
        logic                 rx_done;
        logic                 rx_ok;
        logic                 rx_sym_err;
        logic                 rx_bal_err;
    } blc_state_t;

endpackage

// File: logic/blc_fifo.sv
// small first-word-fall-through fifo with valid/ready on both sides
// assumes one clock, async active-high reset, clock enable freezes it
`timescale 1ns/1ps

module blc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } blc_fifo_st_t;

    blc_fifo_st_t r_reg;
    blc_fifo_st_t r_next;
    logic         full;
    logic         empty;

    assign empty     = r_reg.wp == r_reg.rp;
    assign full      = (r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = r_reg.mem[r_reg.rp[AW-1:0]];

    always_comb begin
        r_next = r_reg;
        if (in_valid && !full) begin
            r_next.mem[r_reg.wp[AW-1:0]] = in_data;
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

endmodule

// File: verif/blc_codec_props.sv
// pin assertions for blc_codec
// bound onto every blc_codec instance from the bench file
`timescale 1ns/1ps
`include "blc_defs.svh"
module blc_codec_props #(
    parameter logic [`BLC_CNT_W-1:0] SLOT_CYC = 16'h10
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tx_busy,
    input wire logic txd,
    input wire logic tx_sel_n,
    input wire logic rx_sel_n,
    input wire logic rx_en,
    input wire logic rx_valid,
    input wire logic rx_done,
    input wire logic rx_ok
);
    logic        last_reg;
    logic [15:0] run_reg;
    // cycles since the last txd edge, cleared while idle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_reg <= 1'h0;
            run_reg  <= 16'h0;
        end else begin
            last_reg <= txd;
            run_reg  <= (!tx_busy || txd != last_reg) ? 16'h0 : run_reg + 16'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_idle_low: assert property (tx_sel_n |-> !txd) else $error("txd high when idle");
    chk_edge_min: assert property (tx_busy && $past(tx_busy) && txd != last_reg |-> run_reg >= SLOT_CYC - 16'h1)
        else $error("txd edges too close");
    chk_edge_max: assert property (tx_busy |-> run_reg < 16'h28 * SLOT_CYC) else $error("txd edges too far");
    chk_busy_sel: assert property (tx_busy |-> !tx_sel_n) else $error("busy while deselected");
    chk_half_dup: assert property (!tx_sel_n |-> rx_sel_n) else $error("rx selected in tx");
    chk_rx_gate: assert property (!rx_en |-> rx_sel_n) else $error("rx selected while off");
    chk_byte_pulse: assert property (rx_valid |=> !rx_valid) else $error("rx_valid too long");
    chk_done_pulse: assert property (rx_done |=> !rx_done) else $error("rx_done too long");
    chk_ok_hold: assert property ($changed(rx_ok) |-> rx_done) else $error("rx_ok moved alone");
    cov_pkt_ok: cover property (rx_done && rx_ok);
    cov_tx_start: cover property ($rose(tx_busy));
    cov_byte: cover property (rx_valid);
endmodule

// File: verif/blc_radio_model.sv
// radio module model: raw txd to air, air to rxd with carrier detect
// assumes one clock; rxd is noise when deselected or settling
`timescale 1ns/1ps
module blc_radio_model #(
    parameter int NOISE_CYC = 800
) (
    input wire logic clk_sys,
    input wire logic tx_sel_n,
    input wire logic txd,
    input wire logic rx_sel_n,
    output logic     rxd,
    output logic     carrier_detect_output,
    input wire logic air_in,
    input wire logic air_on,
    output logic     air_out,
    output logic     air_on_out
);
    logic noise_reg = 1'b0;
    int   on_reg = 0;
    always_ff @(posedge clk_sys) begin
        noise_reg <= !noise_reg;
        on_reg    <= air_on ? on_reg + 1 : 0;
    end
    assign air_out = !tx_sel_n && txd;
    assign air_on_out = !tx_sel_n;
    assign carrier_detect_output = !rx_sel_n && air_on;
    assign rxd = (carrier_detect_output && on_reg >= NOISE_CYC) ? air_in : noise_reg;
endmodule

// File: verif/blc_codec_bench.sv
// bench: two codec nodes over modelled radios; node 1 sends in the thirds test, node 0 in the other packet tests; the reset test sends nothing
// assumes logic/ files and the verif models compiled before it
`timescale 1ns/1ps
module blc_codec_bench;
    localparam logic [15:0] SLOT = 16'h10;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b1;
    logic [1:0] mode = 2'h0;
    logic       dup_en = 1'b0;
    logic       tx_valid[2], tx_go[2], rx_en[2], tx_ready[2], tx_busy[2], txd[2], tx_sel_n[2], rx_sel_n[2];
    logic       rx_valid[2], rx_done[2], rx_ok[2], rx_sym_err[2], rx_bal_err[2], rxd[2], cd[2], air[2], air_on[2];
    logic [7:0] tx_data[2], rx_data[2];
    int         n_fail = 0;
    int         comparisons = 0;
    int         cycles = 0;
    always #5 clk_sys = !clk_sys;
    for (genvar i = 0; i < 2; i++) begin : g_node
        blc_codec #(.SLOT_CYC(SLOT)) DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .mode(mode), .dup_en(dup_en),
            .tx_valid(tx_valid[i]), .tx_ready(tx_ready[i]), .tx_data(tx_data[i]), .tx_go(tx_go[i]),
            .tx_busy(tx_busy[i]), .rx_en(rx_en[i]), .rx_data(rx_data[i]), .rx_valid(rx_valid[i]),
            .rx_done(rx_done[i]), .rx_ok(rx_ok[i]), .rx_sym_err(rx_sym_err[i]), .rx_bal_err(rx_bal_err[i]),
            .txd(txd[i]), .tx_sel_n(tx_sel_n[i]), .rx_sel_n(rx_sel_n[i]), .rxd(rxd[i]), .carrier_detect_output(cd[i]));
        blc_radio_model radio (.clk_sys(clk_sys), .tx_sel_n(tx_sel_n[i]), .txd(txd[i]), .rx_sel_n(rx_sel_n[i]),
            .rxd(rxd[i]), .carrier_detect_output(cd[i]), .air_in(air[1-i]), .air_on(air_on[1-i]),
            .air_out(air[i]), .air_on_out(air_on[i]));
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // node s sends b, the other node receives and judges it
    task automatic run_pkt(input int s, input logic [1:0] m, input logic dp, input logic eb, input logic [7:0] b[$]);
        logic [7:0] got[$];
        int         w;
        @(posedge clk_sys);
        mode       <= m;
        dup_en     <= dp;
        rx_en[1-s] <= 1'b1;
        foreach (b[i]) begin
            tx_valid[s] <= 1'b1;
            tx_data[s]  <= b[i];
            @(negedge clk_sys);
            while (tx_ready[s] !== 1'b1) @(negedge clk_sys);
            @(posedge clk_sys);
        end
        tx_valid[s] <= 1'b0;
        @(negedge clk_sys);
        if (b.size() == 16) check("full", 8'(tx_ready[s]), 8'h0);
        @(posedge clk_sys);
        tx_go[s] <= 1'b1;
        @(posedge clk_sys);
        tx_go[s] <= 1'b0;
        for (w = 0; w < 40000 && rx_done[1-s] !== 1'b1; w++) begin
            @(posedge clk_sys);
            #1;
            if (rx_valid[1-s] === 1'b1) got.push_back(rx_data[1-s]);
        end
        check("count", 8'(got.size()), 8'(b.size()));
        foreach (b[i]) check("data", got[i], b[i]);
        check("sum ok", 8'(rx_ok[1-s]), 8'h1);
        check("idle line", {6'h0, txd[s], tx_sel_n[s]}, 8'h1);
        if (m != blc_pkg::BLC_NRZ) check("sym err", 8'(rx_sym_err[1-s]), 8'h0);
        if (eb) check("bal err", 8'(rx_bal_err[1-s]), 8'h1);
        @(posedge clk_sys);
        rx_en[1-s] <= 1'b0;
        $display("test done mode %0d dup %0d bytes %0d", m, dp, b.size());
    endtask
    task automatic t_reset();
        #1;
        check("reset pins", {3'h0, txd[0], tx_sel_n[0], tx_busy[0], tx_ready[0], rx_valid[0]}, 8'h0A);
        $display("test done reset");
    endtask
    task automatic t_manch();
        run_pkt(0, blc_pkg::BLC_MANCH, 1'b0, 1'b0, '{8'h12, 8'h34, 8'hFF, 8'h00});
    endtask
    task automatic t_thirds();
        run_pkt(1, blc_pkg::BLC_THIRDS, 1'b0, 1'b0, '{8'hA5, 8'h3C});
    endtask
    task automatic t_nrz();
        run_pkt(0, blc_pkg::BLC_NRZ, 1'b0, 1'b0, '{8'h5A, 8'hC3, 8'h96});
    endtask
    task automatic t_dup();
        run_pkt(0, blc_pkg::BLC_MANCH, 1'b1, 1'b0, '{8'h81, 8'h7E});
    endtask
    task automatic t_bad();
        run_pkt(0, blc_pkg::BLC_NRZ, 1'b0, 1'b1, '{8'h0F, 8'h5A});
    endtask
    task automatic t_full();
        logic [7:0] q[$];
        for (int i = 0; i < 16; i++) q.push_back(8'(i * 17 + 3));
        run_pkt(0, blc_pkg::BLC_MANCH, 1'b0, 1'b0, q);
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        foreach (tx_valid[i]) begin
            tx_valid[i] = 1'b0;
            tx_go[i]    = 1'b0;
            rx_en[i]    = 1'b0;
            tx_data[i]  = 8'h00;
        end
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_manch();
        t_thirds();
        t_nrz();
        t_dup();
        t_bad();
        t_full();
        complete_run();
    end
endmodule
bind blc_codec blc_codec_props #(.SLOT_CYC(SLOT_CYC)) u_props (.clk_sys(clk_sys), .rst(rst), .tx_busy(tx_busy),
    .txd(txd), .tx_sel_n(tx_sel_n), .rx_sel_n(rx_sel_n), .rx_en(rx_en), .rx_valid(rx_valid), .rx_done(rx_done),
    .rx_ok(rx_ok));
